// file: core/dpk_regbank.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpk_map.svh"

module dpk_regbank #(
    parameter bit TRACE_PORT_PRESENT = 1'b1
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // Register port.
    input wire logic [`DPK_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    output logic [31:0] o_rdata,
    // Requests from the debug subsystem and acknowledges back.
    input wire dpk_pkg::dpk_req_s i_req,
    output dpk_pkg::dpk_req_s o_ack,
    // Clock settings: index 0 trace, 1 debug bus, 2 debug core.
    output dpk_pkg::dpk_clk_s [2:0] o_clk_cfg,
    output logic [31:0] o_clock_force,
    // Interrupt.
    output logic o_irq
);

    localparam logic [31:0] DIV_RST [3] = '{`DPK_RST_TRC_DIV, `DPK_RST_DBG_DIV, `DPK_RST_DBG_DIV};

    function automatic dpk_pkg::dpk_reg_e dpk_decode(input logic [`DPK_ADDR_W-1:0] a);
        dpk_pkg::dpk_reg_e r;
        r = dpk_pkg::REG_NONE;
        unique case (a)
            `DPK_OFF_DBG_PWR_ST: r = dpk_pkg::REG_DBG_PWR_ST;
            `DPK_OFF_DBG_RST_ST: r = dpk_pkg::REG_DBG_RST_ST;
            `DPK_OFF_SYS_PWR_ST: r = dpk_pkg::REG_SYS_PWR_ST;
            `DPK_OFF_SYS_RST_ST: r = dpk_pkg::REG_SYS_RST_ST;
            `DPK_OFF_DEBUG_POWER_REQUEST_ACK: r = dpk_pkg::REG_DEBUG_POWER_REQUEST_ACK;
            `DPK_OFF_DEBUG_RESET_REQUEST_ACK: r = dpk_pkg::REG_DEBUG_RESET_REQUEST_ACK;
            `DPK_OFF_SYSTEM_POWERUP_REQUEST_ACK: r = dpk_pkg::REG_SYSTEM_POWERUP_REQUEST_ACK;
            `DPK_OFF_SYSTEM_RESET_REQUEST_ACK: r = dpk_pkg::REG_SYSTEM_RESET_REQUEST_ACK;
            `DPK_OFF_TRC_CTRL: r = TRACE_PORT_PRESENT ? dpk_pkg::REG_TRC_CTRL : dpk_pkg::REG_NONE;
            `DPK_OFF_TRC_DIV: r = TRACE_PORT_PRESENT ? dpk_pkg::REG_TRC_DIV : dpk_pkg::REG_NONE;
            `DPK_OFF_BUS_CTRL: r = dpk_pkg::REG_BUS_CTRL;
            `DPK_OFF_BUS_DIV: r = dpk_pkg::REG_BUS_DIV;
            `DPK_OFF_CORE_CTRL: r = dpk_pkg::REG_CORE_CTRL;
            `DPK_OFF_CORE_DIV: r = dpk_pkg::REG_CORE_DIV;
            `DPK_OFF_FORCE_ST: r = dpk_pkg::REG_FORCE_ST;
            `DPK_OFF_FORCE_SET: r = dpk_pkg::REG_FORCE_SET;
            `DPK_OFF_FORCE_CLR: r = dpk_pkg::REG_FORCE_CLR;
            `DPK_OFF_IRQ_ST: r = dpk_pkg::REG_IRQ_ST;
            `DPK_OFF_IRQ_MASK: r = dpk_pkg::REG_IRQ_MASK;
            default: r = dpk_pkg::REG_NONE;
        endcase
        return r;
    endfunction

    dpk_pkg::dpk_reg_e wr_sel;
    dpk_pkg::dpk_reg_e rd_sel;
    logic [int'(dpk_pkg::REG_NONE):0] wr_hit;
    logic [3:0] ack_q;
    logic [31:0] ctrl_q [3];
    logic [31:0] div_q [3];
    logic [31:0] force_q;
    logic [`DPK_IRQ_W-1:0] irq_st_q;
    logic [`DPK_IRQ_W-1:0] irq_st_d;
    logic [`DPK_IRQ_W-1:0] irq_mask_q;
    logic [`DPK_IRQ_W-1:0] irq_ev;
    logic pwr_req_prev_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    // Writes to reserved or absent offsets hit nothing and are dropped.
    always_comb begin
        wr_sel = dpk_decode(i_addr);
        rd_sel = dpk_decode(i_addr);
        for (int k = 0; k <= int'(dpk_pkg::REG_NONE); k++) begin
            wr_hit[k] = i_wr_stb && (int'(wr_sel) == k) && (k != int'(dpk_pkg::REG_NONE));
        end
    end

    // Acknowledge bits, one per channel.
    for (genvar g = 0; g < 4; g++) begin : g_ack
        always_ff @(posedge i_sys_clk) begin
            if (!i_rst_b) begin
                ack_q[g] <= 1'b0;
            end else if (wr_hit[int'(dpk_pkg::REG_DEBUG_POWER_REQUEST_ACK) + g]) begin
                ack_q[g] <= i_wdata[0];
            end
        end
    end

    assign o_ack = dpk_pkg::dpk_req_s'(ack_q);

    // Clock control and divider pairs; the trace pair exists only with the trace port unit.
    for (genvar g = 0; g < 3; g++) begin : g_clk
        if (g == 0 && !TRACE_PORT_PRESENT) begin : g_absent
            always_ff @(posedge i_sys_clk) begin
                ctrl_q[g] <= `DPK_RST_ZERO;
                div_q[g] <= `DPK_RST_ZERO;
            end
        end else begin : g_present
            always_ff @(posedge i_sys_clk) begin
                if (!i_rst_b) begin
                    ctrl_q[g] <= `DPK_RST_CLK_CTRL;
                end else if (wr_hit[int'(dpk_pkg::REG_TRC_CTRL) + g]) begin
                    ctrl_q[g] <= i_wdata;
                end
            end
            always_ff @(posedge i_sys_clk) begin
                if (!i_rst_b) begin
                    div_q[g] <= DIV_RST[g];
                end else if (wr_hit[int'(dpk_pkg::REG_TRC_DIV) + g]) begin
                    div_q[g] <= i_wdata;
                end
            end
        end
        assign o_clk_cfg[g].ctrl = ctrl_q[g];
        assign o_clk_cfg[g].div = div_q[g];
    end

    // Clock-force bits: set and clear registers act only on bits written as one.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            force_q <= `DPK_RST_ZERO;
        end else if (wr_hit[int'(dpk_pkg::REG_FORCE_SET)]) begin
            force_q <= force_q | i_wdata;
        end else if (wr_hit[int'(dpk_pkg::REG_FORCE_CLR)]) begin
            force_q <= force_q & ~i_wdata;
        end
    end

    assign o_clock_force = force_q;

    // Debug power request edges raise sticky interrupt bits; a new edge beats a clear.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            pwr_req_prev_q <= 1'b0;
        end else begin
            pwr_req_prev_q <= i_req.dbg_pwr;
        end
    end

    always_comb begin
        irq_ev[`DPK_IRQ_BIT_RISE] = i_req.dbg_pwr && !pwr_req_prev_q;
        irq_ev[`DPK_IRQ_BIT_FALL] = !i_req.dbg_pwr && pwr_req_prev_q;
        irq_st_d = irq_st_q;
        if (wr_hit[int'(dpk_pkg::REG_IRQ_ST)]) begin
            irq_st_d = irq_st_q & ~i_wdata[`DPK_IRQ_W-1:0];
        end
        irq_st_d = irq_st_d | irq_ev;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            irq_st_q <= '0;
        end else begin
            irq_st_q <= irq_st_d;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            irq_mask_q <= '0;
        end else if (wr_hit[int'(dpk_pkg::REG_IRQ_MASK)]) begin
            irq_mask_q <= i_wdata[`DPK_IRQ_W-1:0];
        end
    end

    assign o_irq = |(irq_st_q & irq_mask_q);

    // Read mux; data stand only in the cycle after the read strobe.
    always_comb begin
        rdata_d = '0;
        unique case (rd_sel)
            dpk_pkg::REG_DBG_PWR_ST: rdata_d = {31'h0, i_req.dbg_pwr};
            dpk_pkg::REG_DBG_RST_ST: rdata_d = {31'h0, i_req.dbg_rst};
            dpk_pkg::REG_SYS_PWR_ST: rdata_d = {31'h0, i_req.sys_pwr};
            dpk_pkg::REG_SYS_RST_ST: rdata_d = {31'h0, i_req.sys_rst};
            dpk_pkg::REG_DEBUG_POWER_REQUEST_ACK: rdata_d = {31'h0, ack_q[0]};
            dpk_pkg::REG_DEBUG_RESET_REQUEST_ACK: rdata_d = {31'h0, ack_q[1]};
            dpk_pkg::REG_SYSTEM_POWERUP_REQUEST_ACK: rdata_d = {31'h0, ack_q[2]};
            dpk_pkg::REG_SYSTEM_RESET_REQUEST_ACK: rdata_d = {31'h0, ack_q[3]};
            dpk_pkg::REG_TRC_CTRL: rdata_d = ctrl_q[0];
            dpk_pkg::REG_BUS_CTRL: rdata_d = ctrl_q[1];
            dpk_pkg::REG_CORE_CTRL: rdata_d = ctrl_q[2];
            dpk_pkg::REG_TRC_DIV: rdata_d = div_q[0];
            dpk_pkg::REG_BUS_DIV: rdata_d = div_q[1];
            dpk_pkg::REG_CORE_DIV: rdata_d = div_q[2];
            dpk_pkg::REG_FORCE_ST: rdata_d = force_q;
            dpk_pkg::REG_IRQ_ST: rdata_d = {30'h0, irq_st_q};
            dpk_pkg::REG_IRQ_MASK: rdata_d = {30'h0, irq_mask_q};
            default: rdata_d = '0;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= i_rd_stb ? rdata_d : '0;
        end
    end

    assign o_rdata = rdata_q;

    // Checks.
    sequence seq_wr(logic [`DPK_ADDR_W-1:0] a);
        i_wr_stb && i_addr == a;
    endsequence

    sequence seq_rd(logic [`DPK_ADDR_W-1:0] a);
        i_rd_stb && i_addr == a;
    endsequence

    property p_ack_readback(logic [`DPK_ADDR_W-1:0] a, logic [`DPK_ADDR_W-1:0] b);
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_wr(a) ##1 seq_rd(a) |=> o_rdata == {31'h0, $past(i_wdata[0], 2)};
    endproperty

    AST_DBG_PWR_STATUS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_rd(`DPK_OFF_DBG_PWR_ST) |=> o_rdata == {31'h0, $past(i_req.dbg_pwr)})
        else $error("debug power status read does not show request level");

    AST_ACK_DRIVES_OUT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_wr(`DPK_OFF_DEBUG_POWER_REQUEST_ACK) |=> o_ack.dbg_pwr == $past(i_wdata[0]))
        else $error("debug power acknowledge output does not follow written bit");

    AST_RESET_STATE: assert property (@(posedge i_sys_clk)
        $rose(i_rst_b) |-> (o_ack == '0 && irq_st_q == '0 && o_irq == 1'b0))
        else $error("acknowledge or interrupt state not cleared by reset");

    AST_DEBUG_RESET_REQUEST_ACK_RB: assert property (p_ack_readback(`DPK_OFF_DEBUG_RESET_REQUEST_ACK, '0))
        else $error("debug reset acknowledge read back wrong");

    AST_SYSTEM_POWERUP_REQUEST_ACK_RB: assert property (p_ack_readback(`DPK_OFF_SYSTEM_POWERUP_REQUEST_ACK, '0))
        else $error("system power acknowledge read back wrong");

    AST_SYSTEM_RESET_REQUEST_ACK_RB: assert property (p_ack_readback(`DPK_OFF_SYSTEM_RESET_REQUEST_ACK, '0))
        else $error("system reset acknowledge read back wrong");

    AST_TRACE_RESET: assert property (@(posedge i_sys_clk)
        $rose(i_rst_b) |-> (TRACE_PORT_PRESENT ?
            (o_clk_cfg[0].ctrl == `DPK_RST_CLK_CTRL && o_clk_cfg[0].div == `DPK_RST_TRC_DIV) :
            (o_clk_cfg[0] == '0)))
        else $error("trace clock pair has wrong reset value");

    AST_BUS_CLK_RESET: assert property (@(posedge i_sys_clk)
        $rose(i_rst_b) |->
        (o_clk_cfg[1].ctrl == `DPK_RST_CLK_CTRL && o_clk_cfg[1].div == `DPK_RST_DBG_DIV))
        else $error("debug bus clock pair has wrong reset value");

    AST_CORE_CLK_RESET: assert property (@(posedge i_sys_clk)
        $rose(i_rst_b) |-> o_clk_cfg[2] == o_clk_cfg[1])
        else $error("debug core clock pair differs from debug bus pair at reset");

    AST_FORCE_SET_CLR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_wr(`DPK_OFF_FORCE_SET) ##1 seq_wr(`DPK_OFF_FORCE_CLR) |=>
        o_clock_force == (($past(o_clock_force, 2) | $past(i_wdata, 2)) & ~$past(i_wdata)))
        else $error("clock force set then clear gives wrong status");

    AST_IRQ_W1C: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_wr(`DPK_OFF_IRQ_ST) ##0 (i_wdata[0] && !irq_ev[0]) |=> !irq_st_q[0])
        else $error("write one did not clear interrupt status bit");

    AST_IRQ_EVENT_WINS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $rose(i_req.dbg_pwr) |=> irq_st_q[0])
        else $error("debug power request edge lost");

    AST_RESERVED_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_rd_stb && dpk_decode(i_addr) == dpk_pkg::REG_NONE |=> o_rdata == '0)
        else $error("reserved offset did not read as zero");

    // Each status register shows its request level as sampled at the read edge.
    AST_DBG_RST_STATUS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_rd(`DPK_OFF_DBG_RST_ST) |=> o_rdata == {31'h0, $past(i_req.dbg_rst)})
        else $error("debug reset status read does not show request level");

    AST_SYS_PWR_STATUS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_rd(`DPK_OFF_SYS_PWR_ST) |=> o_rdata == {31'h0, $past(i_req.sys_pwr)})
        else $error("system power status read does not show request level");

    AST_SYS_RST_STATUS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_rd(`DPK_OFF_SYS_RST_ST) |=> o_rdata == {31'h0, $past(i_req.sys_rst)})
        else $error("system reset status read does not show request level");

    AST_DEBUG_POWER_REQUEST_ACK_RB: assert property (p_ack_readback(`DPK_OFF_DEBUG_POWER_REQUEST_ACK, '0))
        else $error("debug power acknowledge read back wrong");

    // Every acknowledge output follows bit zero of its register one cycle after the write.
    AST_DEBUG_RESET_REQUEST_ACK_OUT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_wr(`DPK_OFF_DEBUG_RESET_REQUEST_ACK) |=> o_ack.dbg_rst == $past(i_wdata[0]))
        else $error("debug reset acknowledge output does not follow written bit");

    AST_SYSTEM_POWERUP_REQUEST_ACK_OUT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_wr(`DPK_OFF_SYSTEM_POWERUP_REQUEST_ACK) |=> o_ack.sys_pwr == $past(i_wdata[0]))
        else $error("system power acknowledge output does not follow written bit");

    AST_SYSTEM_RESET_REQUEST_ACK_OUT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_wr(`DPK_OFF_SYSTEM_RESET_REQUEST_ACK) |=> o_ack.sys_rst == $past(i_wdata[0]))
        else $error("system reset acknowledge output does not follow written bit");

    // Written state other than interrupt status holds in every cycle without a write.
    AST_ACK_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !i_wr_stb |=> $stable(o_ack))
        else $error("acknowledge outputs changed without a write");

    AST_CLK_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !i_wr_stb |=> $stable(o_clk_cfg))
        else $error("clock settings changed without a write");

    AST_FORCE_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !i_wr_stb |=> $stable(o_clock_force))
        else $error("clock force status changed without a write");

    AST_RESERVED_WRITE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_wr_stb && dpk_decode(i_addr) == dpk_pkg::REG_NONE |=>
        ($stable(o_ack) && $stable(o_clk_cfg) && $stable(o_clock_force)))
        else $error("write to a reserved offset changed state");

    AST_RDATA_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !i_rd_stb |=> o_rdata == '0)
        else $error("read data not zero outside the answer cycle");

    // A single write to a clock word lands whole on the next cycle.
    AST_TRACE_CTRL_WR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_wr(`DPK_OFF_TRC_CTRL) |=>
        o_clk_cfg[0].ctrl == (TRACE_PORT_PRESENT ? $past(i_wdata) : `DPK_RST_ZERO))
        else $error("trace clock control write wrong");

    AST_TRACE_DIV_WR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_wr(`DPK_OFF_TRC_DIV) |=>
        o_clk_cfg[0].div == (TRACE_PORT_PRESENT ? $past(i_wdata) : `DPK_RST_ZERO))
        else $error("trace clock divider write wrong");

    AST_BUS_CTRL_WR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_wr(`DPK_OFF_BUS_CTRL) |=> o_clk_cfg[1].ctrl == $past(i_wdata))
        else $error("debug bus clock control write wrong");

    AST_BUS_DIV_WR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_wr(`DPK_OFF_BUS_DIV) |=> o_clk_cfg[1].div == $past(i_wdata))
        else $error("debug bus clock divider write wrong");

    AST_CORE_CTRL_WR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_wr(`DPK_OFF_CORE_CTRL) |=> o_clk_cfg[2].ctrl == $past(i_wdata))
        else $error("debug core clock control write wrong");

    AST_CORE_DIV_WR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_wr(`DPK_OFF_CORE_DIV) |=> o_clk_cfg[2].div == $past(i_wdata))
        else $error("debug core clock divider write wrong");

    AST_FORCE_SET: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_wr(`DPK_OFF_FORCE_SET) |=> o_clock_force == ($past(o_clock_force) | $past(i_wdata)))
        else $error("clock force set did not act on written ones");

    AST_FORCE_CLR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_wr(`DPK_OFF_FORCE_CLR) |=> o_clock_force == ($past(o_clock_force) & ~$past(i_wdata)))
        else $error("clock force clear did not act on written ones");

    AST_IRQ_FALL_EVENT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $fell(i_req.dbg_pwr) |=> irq_st_q[1])
        else $error("debug power request falling edge lost");

    AST_IRQ_FALL_W1C: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        seq_wr(`DPK_OFF_IRQ_ST) ##0 (i_wdata[1] && !irq_ev[1]) |=> !irq_st_q[1])
        else $error("write one did not clear falling edge status bit");

    AST_IRQ_STICKY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        irq_st_q[0] && !(i_wr_stb && i_addr == `DPK_OFF_IRQ_ST && i_wdata[0]) |=> irq_st_q[0])
        else $error("interrupt status bit dropped without a clearing write");

    AST_RESET_CLEARS: assert property (@(posedge i_sys_clk)
        !i_rst_b |=> (irq_st_q == '0 && o_rdata == '0 && o_clock_force == '0))
        else $error("interrupt status, read data or clock force not cleared by reset");

endmodule

`default_nettype wire

// file: core/dpk_map.svh
// How it works
// - Debug power request status at offset zero is read-only and resets to zero.
// - Debug power acknowledge at offset four is read-write and resets to zero.
// - Debug reset request status and acknowledge sit at 0x020 and 0x024, reset zero.
// - System power-up request status and acknowledge sit at 0x030 and 0x034, reset zero.
// - System reset request status and acknowledge sit at 0x050 and 0x054, reset zero.
// - Trace clock control and divider exist only with the trace port unit.
// - Debug bus clock control and divider are read-write with their reset patterns.
// - Debug core clock pair is read-write with the debug bus pair's resets.
// - Clock-force status is readable; separate write-only set and clear registers.
// - Debug power request interrupt status resets to zero; writing one clears.
// - Status bit zero shows the live debug power-up request level.
// - Acknowledge bit zero drives the outgoing debug power-up acknowledge.
`ifndef DPK_MAP_SVH
`define DPK_MAP_SVH

`define DPK_ADDR_W 12
`define DPK_OFF_DBG_PWR_ST 12'h000
`define DPK_OFF_DEBUG_POWER_REQUEST_ACK 12'h004
`define DPK_OFF_DBG_RST_ST 12'h020
`define DPK_OFF_DEBUG_RESET_REQUEST_ACK 12'h024
`define DPK_OFF_SYS_PWR_ST 12'h030
`define DPK_OFF_SYSTEM_POWERUP_REQUEST_ACK 12'h034
`define DPK_OFF_SYS_RST_ST 12'h050
`define DPK_OFF_SYSTEM_RESET_REQUEST_ACK 12'h054
`define DPK_OFF_TRC_CTRL 12'h810
`define DPK_OFF_TRC_DIV 12'h814
`define DPK_OFF_BUS_CTRL 12'h820
`define DPK_OFF_BUS_DIV 12'h824
`define DPK_OFF_CORE_CTRL 12'h830
`define DPK_OFF_CORE_DIV 12'h834
`define DPK_OFF_FORCE_ST 12'hA00
`define DPK_OFF_FORCE_SET 12'hA04
`define DPK_OFF_FORCE_CLR 12'hA08
`define DPK_OFF_IRQ_ST 12'hB00
`define DPK_OFF_IRQ_MASK 12'hB80

`define DPK_RST_ZERO 32'h0000_0000
`define DPK_RST_CLK_CTRL 32'h0000_0101
`define DPK_RST_TRC_DIV 32'h001F_001F
`define DPK_RST_DBG_DIV 32'h000F_000F

`define DPK_IRQ_W 2
`define DPK_IRQ_BIT_RISE 0
`define DPK_IRQ_BIT_FALL 1

`endif

// file: core/dpk_pkg.sv
package dpk_pkg;

    // Register selected by an address; order puts the four status registers before the four acknowledges.
    typedef enum {
        REG_DBG_PWR_ST,
        REG_DBG_RST_ST,
        REG_SYS_PWR_ST,
        REG_SYS_RST_ST,
        REG_DEBUG_POWER_REQUEST_ACK,
        REG_DEBUG_RESET_REQUEST_ACK,
        REG_SYSTEM_POWERUP_REQUEST_ACK,
        REG_SYSTEM_RESET_REQUEST_ACK,
        REG_TRC_CTRL,
        REG_BUS_CTRL,
        REG_CORE_CTRL,
        REG_TRC_DIV,
        REG_BUS_DIV,
        REG_CORE_DIV,
        REG_FORCE_ST,
        REG_FORCE_SET,
        REG_FORCE_CLR,
        REG_IRQ_ST,
        REG_IRQ_MASK,
        REG_NONE
    } dpk_reg_e;

    // Four request and acknowledge channels: debug power, debug reset, system power, system reset.
    typedef struct packed {
        logic sys_rst;
        logic sys_pwr;
        logic dbg_rst;
        logic dbg_pwr;
    } dpk_req_s;

    // Control and divider words of one generated clock.
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] div;
    } dpk_clk_s;

endpackage

// file: test/dpk_req_model.sv
`timescale 1ns/1ps
`default_nettype none

module dpk_req_model #(
    parameter int LAG = 1
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // Levels the bench wants on each request channel.
    input wire logic [3:0] i_want,
    // Request levels toward the register bank.
    output dpk_pkg::dpk_req_s o_req
);
    // A short pipe lets the far side answer promptly or slowly.
    logic [3:0] pipe_q [LAG];

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            for (int i = 0; i < LAG; i++) begin
                pipe_q[i] <= 4'h0;
            end
        end else begin
            pipe_q[0] <= i_want;
            for (int i = 1; i < LAG; i++) begin
                pipe_q[i] <= pipe_q[i-1];
            end
        end
    end

    assign o_req = dpk_pkg::dpk_req_s'(pipe_q[LAG-1]);
endmodule

`default_nettype wire

// file: test/tb_debug_power_clock_register_bank.sv
`timescale 1ns/1ps
`default_nettype none

module tb_debug_power_clock_register_bank;
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [11:0] i_addr = 12'h000;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr_stb = 1'b0;
    logic i_rd_stb = 1'b0;
    logic [31:0] o_rdata;
    logic [3:0] want = 4'h0;
    dpk_pkg::dpk_req_s req;
    dpk_pkg::dpk_req_s o_ack;
    dpk_pkg::dpk_clk_s [2:0] o_clk_cfg;
    logic [31:0] o_clock_force;
    logic o_irq;
    int failures = 0;
    int checked = 0;
    logic [11:0] map_addr [16] = '{12'h000, 12'h004, 12'h020, 12'h024, 12'h030, 12'h034,
        12'h050, 12'h054, 12'h810, 12'h814, 12'h820, 12'h824, 12'h830, 12'h834, 12'hA00,
        12'hB00};
    logic [31:0] map_rst [16] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0101,
        32'h001F_001F, 32'h0000_0101, 32'h000F_000F, 32'h0000_0101, 32'h000F_000F,
        32'h0000_0000, 32'h0000_0000};
    logic [11:0] st_addr [4] = '{12'h000, 12'h020, 12'h030, 12'h050};
    logic [11:0] resv [6] = '{12'h008, 12'h7FC, 12'h818, 12'h83C, 12'hB04, 12'hFFC};

    dpk_req_model #(.LAG(2)) i_model (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_want(want),
        .o_req(req)
    );

    dpk_regbank #(.TRACE_PORT_PRESENT(1'b1)) i_dut (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr_stb(i_wr_stb),
        .i_rd_stb(i_rd_stb),
        .o_rdata(o_rdata),
        .i_req(req),
        .o_ack(o_ack),
        .o_clk_cfg(o_clk_cfg),
        .o_clock_force(o_clock_force),
        .o_irq(o_irq)
    );

    initial begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bus tasks start and end right at a rising edge, so requests may follow with no gap.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_wr_stb <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr_stb <= 1'b0;
    endtask

    // Two writes on consecutive edges; the strobe stays high between them.
    task automatic wr2(input logic [11:0] a0, input logic [31:0] d0,
            input logic [11:0] a1, input logic [31:0] d1);
        i_wr_stb <= 1'b1;
        i_addr <= a0;
        i_wdata <= d0;
        @(posedge i_sys_clk);
        i_addr <= a1;
        i_wdata <= d1;
        @(posedge i_sys_clk);
        i_wr_stb <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe; the edge ending that cycle samples them.
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        i_rd_stb <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd_stb <= 1'b0;
        @(posedge i_sys_clk);
        chk(o_rdata, exp);
    endtask

    task automatic results();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic t_reset();
        for (int i = 0; i < 16; i++) begin
            rdchk(map_addr[i], map_rst[i]);
        end
        chk({28'h000_0000, o_ack}, 32'h0000_0000);
        chk(o_clk_cfg[0].div, 32'h001F_001F);
        chk(o_clk_cfg[2].div, 32'h000F_000F);
    endtask

    task automatic t_ack();
        for (int k = 0; k < 4; k++) begin
            wr(st_addr[k] + 12'h004, 32'hFFFF_FFFF);
            rdchk(st_addr[k] + 12'h004, 32'h0000_0001);
            chk({28'h000_0000, o_ack}, 32'h0000_0001 << k);
            wr2(st_addr[k] + 12'h004, 32'h0000_0000, st_addr[k], 32'hFFFF_FFFF);
            rdchk(st_addr[k], 32'h0000_0000);
        end
    endtask

    task automatic t_status();
        for (int k = 0; k < 4; k++) begin
            want <= 4'h1 << k;
            repeat (4) @(posedge i_sys_clk);
            for (int j = 0; j < 4; j++) begin
                rdchk(st_addr[j], {31'h0000_0000, j == k});
            end
        end
        want <= 4'h0;
        repeat (4) @(posedge i_sys_clk);
    endtask

    task automatic t_clk();
        for (int i = 0; i < 6; i++) begin
            wr(map_addr[8+i], 32'hA5C3_0000 | i);
            rdchk(map_addr[8+i], 32'hA5C3_0000 | i);
        end
        chk(o_clk_cfg[0].ctrl, 32'hA5C3_0000);
        chk(o_clk_cfg[1].div, 32'hA5C3_0003);
        chk(o_clk_cfg[2].div, 32'hA5C3_0005);
        chk(o_clk_cfg[0].div, 32'hA5C3_0001);
        chk(o_clk_cfg[1].ctrl, 32'hA5C3_0002);
        chk(o_clk_cfg[2].ctrl, 32'hA5C3_0004);
    endtask

    task automatic t_force();
        wr(12'hA04, 32'h0000_00F0);
        rdchk(12'hA00, 32'h0000_00F0);
        wr2(12'hA04, 32'h0000_0300, 12'hA08, 32'h0000_0130);
        rdchk(12'hA00, 32'h0000_02C0);
        wr(12'hA00, 32'hFFFF_FFFF);
        rdchk(12'hA00, 32'h0000_02C0);
        chk(o_clock_force, 32'h0000_02C0);
    endtask

    task automatic t_irq();
        wr2(12'hB00, 32'h0000_0003, 12'hB80, 32'h0000_0001);
        rdchk(12'hB80, 32'h0000_0001);
        chk({31'h0000_0000, o_irq}, 32'h0000_0000);
        want <= 4'h1;
        for (int n = 0; n < 8 && o_irq !== 1'b1; n++) begin
            @(posedge i_sys_clk);
        end
        if (o_irq !== 1'b1) begin
            chk({31'h0000_0000, o_irq}, 32'h0000_0001);
            results();
        end
        rdchk(12'hB00, 32'h0000_0001);
        wr(12'hB00, 32'h0000_0001);
        rdchk(12'hB00, 32'h0000_0000);
        chk({31'h0000_0000, o_irq}, 32'h0000_0000);
        want <= 4'h0;
        repeat (4) @(posedge i_sys_clk);
        rdchk(12'hB00, 32'h0000_0002);
        chk({31'h0000_0000, o_irq}, 32'h0000_0000);
        wr(12'hB00, 32'h0000_0002);
        rdchk(12'hB00, 32'h0000_0000);
    endtask

    task automatic t_resv();
        for (int i = 0; i < 6; i++) begin
            wr(resv[i], 32'hFFFF_FFFF);
            rdchk(resv[i], 32'h0000_0000);
        end
        rdchk(12'h810, 32'hA5C3_0000);
        @(posedge i_sys_clk);
        chk(o_rdata, 32'h0000_0000);
    endtask

    // Reset in mid-run must bring written state back to its reset values.
    task automatic t_rerst();
        wr(12'h004, 32'h0000_0001);
        rdchk(12'h004, 32'h0000_0001);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        chk({28'h000_0000, o_ack}, 32'h0000_0000);
        rdchk(12'h810, 32'h0000_0101);
        rdchk(12'hA00, 32'h0000_0000);
        rdchk(12'h004, 32'h0000_0000);
    endtask

    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        t_reset();
        t_ack();
        t_status();
        t_clk();
        t_force();
        t_irq();
        t_resv();
        t_rerst();
        results();
    end
endmodule

`default_nettype wire
